/* verilog/port_merge_regs.svh */
// Register offsets, field positions, width codes and response codes for the port merge and width block
`ifndef PORT_MERGE_REGS_SVH
`define PORT_MERGE_REGS_SVH
`define OFF_SWITCH_CTL      8'h00
`define OFF_PORT_SEL        8'h04
`define OFF_MODE_CTL        8'h08
`define OFF_LINK_CAP        8'h0C
`define OFF_LINK_CTL        8'h10
`define OFF_LINK_STS        8'h14
`define OFF_PHY_STATE       8'h18
`define OFF_MERGE_STS       8'h1C
`define OFF_POLARITY        8'h20
`define BIT_UNLOCK          0
`define BIT_DOWNSTREAM      0
`define BIT_RETRAIN         0
`define BIT_AUTO_BW         15
`define BIT_AUTO_WD         9
`define SH_NEGW             4
`define SH_MAXW             4
`define W_X1                6'h01
`define W_X2                6'h02
`define W_X4                6'h04
`define W_X8                6'h08
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2
`define SYM_FIRST           4'h6
`define SYM_LAST            4'hF
`define TS_INV_ID           8'hB5
`endif

/* verilog/port_merge_pkg.sv */
// Types shared by the port merge and width block
`default_nettype none
package port_merge_pkg;
    typedef enum logic [1:0] {
        TRN_DETECT  = 2'b00,
        TRN_CONFIG  = 2'b01,
        TRN_REVERSE = 2'b10,
        TRN_LINKUP  = 2'b11
    } train_state_t;
    // Hot-plug and status outputs of one port
    typedef struct packed {
        logic attentionInd;
        logic latchLock;
        logic slotPowerEn;
        logic powerInd;
        logic slotResetN;
        logic activityN;
        logic linkupN;
    } port_out_t;
    // Hot-plug inputs of one port, all active low
    typedef struct packed {
        logic attentionButtonN;
        logic retentionLatchN;
        logic presenceDetectN;
        logic powerFaultN;
        logic powerGoodN;
    } port_in_t;
endpackage
`default_nettype wire

/* verilog/port_merge_lane_width_control.sv */
// Port pairing, polarity, lane reversal and width negotiation for sixteen x4 ports
// Operation
// - Only even port merges with next odd
// - Merge straps latched at reset, then fixed
// - Merged pair keeps even port, odd off
// - Deactivated port drives outputs negated; the code holds slotResetN low (asserted)
// - Deactivated port ignores hot-plug inputs
// - Deactivated port has no link
// - Deactivated port registers stay accessible
// - Mode register cannot revive deactivated port
// - Sixteen x4 ports, merged pairs x8
// - Upstream or downstream per operating mode
// - Symbols 6-15 inversion sets lane invert
// - Per-lane polarity, transmitter never inverts
// - Max width is min of cap, lanes
// - Max width write needs unlock, applies at retrain
// - Negotiates x8/x4/x2/x1, reports width
// - Full retrain bit goes through Detect
// - Downstream port tries reversal if wider
// - Accept partner config; else retrain unreversed
// - Honour partner width up and down requests
// - No autonomous change; disable bit reads zero
// - Partner autonomous change sets status flag, on downstream ports only
// - Unlock bit cleared by reset
//
// Local design decisions: the register offsets and the AXI4-Lite slave port.
`include "port_merge_regs.svh"
`default_nettype none
module port_merge_lane_width_control (
    input  wire logic                        clk,
    input  wire logic                        reset,
    input  wire logic [7:0]                  pair_merge_strap_n,
    input  wire port_merge_pkg::port_in_t    hotplugIn     [16],
    output var  port_merge_pkg::port_out_t   hotplugOut    [16],
    input  wire logic [15:0]                 portLinkUp,
    input  wire logic [15:0]                 portActivity,
    input  wire port_merge_pkg::port_out_t   hotplugDrive  [16],
    output logic [15:0]                      portActive,
    output logic [15:0]                      portDownstream,
    output var  port_merge_pkg::port_in_t    hotplugFiltered [16],
    input  wire logic [63:0]                 rxSymValid,
    input  wire logic [63:0]                 rxSymInverted,
    input  wire logic [3:0]                  rxSymIndex,
    input  wire logic [63:0]                 rxData,
    output logic [63:0]                      rxDataCorrected,
    output logic [63:0]                      txInvert,
    input  wire logic [63:0]                 laneTsGood,
    input  wire logic [15:0]                 partnerAcceptRev,
    input  wire logic [15:0]                 partnerCfgOk,
    input  wire logic [15:0]                 partnerReqWidthVld,
    input  wire logic [5:0]                  partnerReqWidth,
    input  wire logic [15:0]                 partnerAutoChange,
    output logic [15:0]                      laneReversed,
    output logic [15:0]                      txAutoChangeBit,
    input  wire logic [7:0]                  s_axi_awaddr,
    input  wire logic                        s_axi_awvalid,
    output logic                             s_axi_awready,
    input  wire logic [31:0]                 s_axi_wdata,
    input  wire logic [3:0]                  s_axi_wstrb,
    input  wire logic                        s_axi_wvalid,
    output logic                             s_axi_wready,
    output logic [1:0]                       s_axi_bresp,
    output logic                             s_axi_bvalid,
    input  wire logic                        s_axi_bready,
    input  wire logic [7:0]                  s_axi_araddr,
    input  wire logic                        s_axi_arvalid,
    output logic                             s_axi_arready,
    output logic [31:0]                      s_axi_rdata,
    output logic [1:0]                       s_axi_rresp,
    output logic                             s_axi_rvalid,
    input  wire logic                        s_axi_rready
);
    // Strap and hot-plug inputs come from pins: two stages before use
    logic [7:0]  strapMeta_reg, strapSync_reg, mergeCfg_reg;
    logic        resetSeen_reg;
    logic        unlock_reg;
    logic [3:0]  portSel_reg;
    logic [15:0] modeDown_reg;
    logic [5:0]  maxWidthCap_reg [16];
    logic [5:0]  maxWidthApplied_reg [16];
    logic [5:0]  negW_reg [16];
    logic [15:0] retrainReq_reg, autoBw_reg, noRevRetry_reg;
    logic [63:0] polInv_reg;
    port_merge_pkg::train_state_t trn_reg [16];
    port_merge_pkg::port_in_t hpMeta_reg [16], hpSync_reg [16];

    // Straps are caught every reset cycle and in the first cycle after release, then frozen
    always_ff @(posedge clk) begin
        strapMeta_reg <= pair_merge_strap_n;
        strapSync_reg <= strapMeta_reg;
        resetSeen_reg <= reset;
        if (reset || resetSeen_reg) begin
            mergeCfg_reg <= ~strapSync_reg;
        end
    end

    // AXI4-Lite: take address and data together, answer next cycle
    logic wrGo, rdGo;
    logic [7:0]  wrAddr;
    logic [31:0] rdMux;
    logic        rdHit, wrHit;
    logic [5:0]  selCap;
    assign wrGo = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    assign rdGo = s_axi_arvalid && !s_axi_rvalid;
    assign s_axi_awready = wrGo;
    assign s_axi_wready = wrGo;
    assign s_axi_arready = rdGo;
    assign wrAddr = s_axi_awaddr;
    assign selCap = maxWidthCap_reg[portSel_reg];
    assign wrHit = (wrAddr == `OFF_SWITCH_CTL) || (wrAddr == `OFF_PORT_SEL)
                || (wrAddr == `OFF_MODE_CTL) || (wrAddr == `OFF_LINK_CAP)
                || (wrAddr == `OFF_LINK_CTL) || (wrAddr == `OFF_LINK_STS)
                || (wrAddr == `OFF_PHY_STATE);

    // Read mux; registers of deactivated ports still answer
    always_comb begin
        rdMux = 32'h0000_0000;
        rdHit = 1'b1;
        case (s_axi_araddr)
            `OFF_SWITCH_CTL: rdMux[`BIT_UNLOCK] = unlock_reg;
            `OFF_PORT_SEL:   rdMux[3:0] = portSel_reg;
            `OFF_MODE_CTL:   rdMux[`BIT_DOWNSTREAM] = modeDown_reg[portSel_reg];
            `OFF_LINK_CAP:   rdMux[`SH_MAXW +: 6] = selCap;
            `OFF_LINK_CTL:   rdMux = 32'h0000_0000; // Autonomous disable reads zero
            `OFF_LINK_STS: begin
                rdMux[`SH_NEGW +: 6] = negW_reg[portSel_reg];
                rdMux[`BIT_AUTO_BW] = autoBw_reg[portSel_reg];
            end
            `OFF_PHY_STATE:  rdMux[1:0] = trn_reg[portSel_reg];
            `OFF_MERGE_STS:  rdMux[15:0] = {8'h00, mergeCfg_reg};
            `OFF_POLARITY:   rdMux[3:0] = polInv_reg[portSel_reg*4 +: 4];
            default:         rdHit = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp  <= `RESP_OKAY;
            s_axi_rdata  <= 32'h0000_0000;
        end else begin
            if (wrGo) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wrHit ? `RESP_OKAY : `RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (rdGo) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rdMux;
                s_axi_rresp  <= rdHit ? `RESP_OKAY : `RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Global control registers; unlock clears on reset
    logic wrByte0;
    assign wrByte0 = wrGo && s_axi_wstrb[0];
    always_ff @(posedge clk) begin
        if (reset) begin
            unlock_reg  <= 1'b0;
            portSel_reg <= 4'h0;
        end else if (wrByte0 && wrAddr == `OFF_SWITCH_CTL) begin
            unlock_reg <= s_axi_wdata[`BIT_UNLOCK];
        end else if (wrByte0 && wrAddr == `OFF_PORT_SEL) begin
            portSel_reg <= s_axi_wdata[3:0];
        end
    end

    // Activity map: odd port of a merged pair is off
    genvar p, l;
    generate
        for (p = 0; p < 16; p++) begin : g_port
            logic active, odd, merged, selWr, reversalUseful;
            logic [5:0] laneLimit, maxW, goodRun, revRun, reqW;
            logic [3:0] good;
            assign odd    = 1'(p % 2);
            assign merged = mergeCfg_reg[p/2];
            assign active = !(odd && merged);
            assign good   = laneTsGood[p*4 +: 4];
            assign selWr  = wrGo && portSel_reg == 4'(p);
            // Merged even port owns its neighbour's lanes
            assign laneLimit = merged ? `W_X8 : `W_X4;
            // Consecutive good lanes counted from lane 0 and from the top
            assign goodRun = !good[0] ? 6'h00 : !good[1] ? `W_X1
                           : !(good[2] && good[3]) ? `W_X2 : laneLimit;
            assign revRun  = !good[3] ? 6'h00 : !good[2] ? `W_X1
                           : !(good[1] && good[0]) ? `W_X2 : laneLimit;
            // Width is the lesser of capability and good lanes
            assign maxW = (maxWidthApplied_reg[p] < goodRun)
                        ? maxWidthApplied_reg[p] : goodRun;
            assign reversalUseful = modeDown_reg[p] && !noRevRetry_reg[p]
                                  && revRun > goodRun;
            assign reqW = partnerReqWidth;
            assign portActive[p] = active;
            assign portDownstream[p] = modeDown_reg[p] && active;
            assign txAutoChangeBit[p] = 1'b0;

            // Outputs of a dead port sit at their negated level, except slotResetN, which is held low (asserted)
            always_ff @(posedge clk) begin
                if (reset || !active) begin
                    hotplugOut[p] <= '{attentionInd: 1'b0, latchLock: 1'b0,
                                       slotPowerEn: 1'b0, powerInd: 1'b0,
                                       slotResetN: 1'b0, activityN: 1'b1,
                                       linkupN: 1'b1};
                end else begin
                    hotplugOut[p] <= '{attentionInd: hotplugDrive[p].attentionInd,
                                       latchLock: hotplugDrive[p].latchLock,
                                       slotPowerEn: hotplugDrive[p].slotPowerEn,
                                       powerInd: hotplugDrive[p].powerInd,
                                       slotResetN: hotplugDrive[p].slotResetN,
                                       activityN: !portActivity[p],
                                       linkupN: !(portLinkUp[p] && trn_reg[p]
                                                  == port_merge_pkg::TRN_LINKUP)};
                end
            end

            // Pin inputs pass two stages; inactive ports see idle highs
            always_ff @(posedge clk) begin
                hpMeta_reg[p] <= hotplugIn[p];
                hpSync_reg[p] <= hpMeta_reg[p];
            end
            assign hotplugFiltered[p] = active ? hpSync_reg[p] : '1;

            // Per-port registers: mode, capability, retrain, flag
            always_ff @(posedge clk) begin
                if (reset) begin
                    modeDown_reg[p]    <= 1'b0;
                    maxWidthCap_reg[p] <= `W_X8;
                    retrainReq_reg[p]  <= 1'b1;
                    autoBw_reg[p]      <= 1'b0;
                end else begin
                    if (selWr && s_axi_wstrb[0] && wrAddr == `OFF_MODE_CTL) begin
                        modeDown_reg[p] <= s_axi_wdata[`BIT_DOWNSTREAM];
                    end
                    if (selWr && s_axi_wstrb[0] && wrAddr == `OFF_LINK_CAP && unlock_reg) begin
                        maxWidthCap_reg[p] <= s_axi_wdata[`SH_MAXW +: 6];
                    end
                    // Retrain request is consumed in Detect
                    if (selWr && s_axi_wstrb[0] && wrAddr == `OFF_PHY_STATE
                        && s_axi_wdata[`BIT_RETRAIN]) begin
                        retrainReq_reg[p] <= 1'b1;
                    end else if (trn_reg[p] == port_merge_pkg::TRN_DETECT) begin
                        retrainReq_reg[p] <= 1'b0;
                    end
                    // Set beats write-one clear
                    if (active && modeDown_reg[p] && partnerAutoChange[p]) begin
                        autoBw_reg[p] <= 1'b1;
                    end else if (selWr && s_axi_wstrb[1] && wrAddr == `OFF_LINK_STS
                                 && s_axi_wdata[`BIT_AUTO_BW]) begin
                        autoBw_reg[p] <= 1'b0;
                    end
                end
            end

            // Training sequencer; a dead port never leaves Detect
            always_ff @(posedge clk) begin
                if (reset || !active) begin
                    trn_reg[p]             <= port_merge_pkg::TRN_DETECT;
                    negW_reg[p]            <= 6'h00;
                    laneReversed[p]        <= 1'b0;
                    noRevRetry_reg[p]      <= 1'b0;
                    maxWidthApplied_reg[p] <= `W_X4;
                end else begin
                    case (trn_reg[p])
                        port_merge_pkg::TRN_DETECT: begin
                            // Capability takes effect only here
                            maxWidthApplied_reg[p] <= (maxWidthCap_reg[p] < laneLimit)
                                                    ? maxWidthCap_reg[p] : laneLimit;
                            laneReversed[p] <= 1'b0;
                            if (goodRun != 6'h00 || revRun != 6'h00) begin
                                trn_reg[p] <= port_merge_pkg::TRN_CONFIG;
                            end
                        end
                        port_merge_pkg::TRN_CONFIG: begin
                            if (reversalUseful) begin
                                trn_reg[p] <= port_merge_pkg::TRN_REVERSE;
                            end else if (maxW != 6'h00) begin
                                // Round down to x8, x4, x2 or x1
                                negW_reg[p] <= maxW >= `W_X8 ? `W_X8 : maxW >= `W_X4
                                            ? `W_X4 : maxW >= `W_X2 ? `W_X2 : `W_X1;
                                noRevRetry_reg[p] <= 1'b0;
                                trn_reg[p] <= port_merge_pkg::TRN_LINKUP;
                            end else begin
                                trn_reg[p] <= port_merge_pkg::TRN_DETECT;
                            end
                        end
                        port_merge_pkg::TRN_REVERSE: begin
                            if (partnerAcceptRev[p]) begin
                                laneReversed[p] <= 1'b1;
                                negW_reg[p] <= revRun;
                                trn_reg[p] <= port_merge_pkg::TRN_LINKUP;
                            end else if (partnerCfgOk[p] && partnerReqWidthVld[p]) begin
                                negW_reg[p] <= reqW;
                                trn_reg[p] <= port_merge_pkg::TRN_LINKUP;
                            end else if (partnerCfgOk[p]) begin
                                noRevRetry_reg[p] <= 1'b1;
                                trn_reg[p] <= port_merge_pkg::TRN_DETECT;
                            end
                        end
                        port_merge_pkg::TRN_LINKUP: begin
                            if (retrainReq_reg[p]) begin
                                trn_reg[p] <= port_merge_pkg::TRN_DETECT;
                            end else if (partnerReqWidthVld[p] && reqW != 6'h00
                                         && reqW <= maxWidthApplied_reg[p]) begin
                                negW_reg[p] <= reqW;
                            end
                        end
                        default: trn_reg[p] <= port_merge_pkg::TRN_DETECT;
                    endcase
                end
            end

            // Per-lane polarity, reversal mapping, no transmit inversion
            for (l = 0; l < 4; l++) begin : g_lane
                localparam int RL = 3 - l;
                logic symWin;
                assign symWin = rxSymIndex >= `SYM_FIRST && rxSymIndex <= `SYM_LAST;
                always_ff @(posedge clk) begin
                    if (reset || trn_reg[p] == port_merge_pkg::TRN_DETECT) begin
                        polInv_reg[p*4+l] <= 1'b0;
                    end else if (trn_reg[p] == port_merge_pkg::TRN_CONFIG && symWin
                                 && rxSymValid[p*4+l] && rxSymInverted[p*4+l]) begin
                        polInv_reg[p*4+l] <= 1'b1;
                    end
                end
                // Logical lane l reads physical lane max-1-l when reversed
                always_ff @(posedge clk) begin
                    if (reset) begin
                        rxDataCorrected[p*4+l] <= 1'b0;
                    end else if (laneReversed[p]) begin
                        rxDataCorrected[p*4+l] <= rxData[p*4+RL] ^ polInv_reg[p*4+RL];
                    end else begin
                        rxDataCorrected[p*4+l] <= rxData[p*4+l] ^ polInv_reg[p*4+l];
                    end
                end
                assign txInvert[p*4+l] = 1'b0;
            end
        end
    endgenerate

    // Checks beside the logic they guard
    AST_ODD_OFF: assert property (@(posedge clk) disable iff (reset)
        mergeCfg_reg[0] |-> !portActive[1] && portActive[0])
        else $error("merged odd port active");
    AST_DEAD_OUT: assert property (@(posedge clk) disable iff (reset)
        !portActive[1] |=> hotplugOut[1].linkupN && hotplugOut[1].activityN)
        else $error("dead port output asserted");
    AST_DEAD_IN: assert property (@(posedge clk) disable iff (reset)
        !portActive[1] |-> hotplugFiltered[1] == '1)
        else $error("dead port input passed");
    AST_DEAD_DETECT: assert property (@(posedge clk) disable iff (reset)
        !portActive[1] |=> trn_reg[1] == port_merge_pkg::TRN_DETECT)
        else $error("dead port trained");
    AST_STRAP_HOLD: assert property (@(posedge clk) disable iff (reset)
        !$past(reset) |-> $stable(mergeCfg_reg))
        else $error("merge config changed");
    AST_LOCKED_CAP: assert property (@(posedge clk) disable iff (reset)
        !unlock_reg |=> $stable(maxWidthCap_reg[0]))
        else $error("locked capability changed");
    AST_NO_TX_INV: assert property (@(posedge clk) txInvert == 64'h0000_0000_0000_0000
        && txAutoChangeBit == 16'h0000) else $error("transmit inversion");
    AST_AUTO_FLAG: assert property (@(posedge clk) disable iff (reset)
        portDownstream[2] && partnerAutoChange[2] |=> autoBw_reg[2])
        else $error("autonomous flag missed");
    AST_RETRAIN: assert property (@(posedge clk) disable iff (reset)
        trn_reg[0] == port_merge_pkg::TRN_LINKUP && retrainReq_reg[0]
        |=> trn_reg[0] == port_merge_pkg::TRN_DETECT)
        else $error("retrain ignored");
endmodule
`default_nettype wire

/* dv/link_partner_model.sv */
// Link partner model feeding training-set status into the switch receive lanes
`default_nettype none
module link_partner_model (
    input  wire logic        clk,
    input  wire logic [63:0] invMask,
    output logic [63:0]      rxSymValid = '0,
    output logic [63:0]      rxSymInverted = '0,
    output logic [3:0]       rxSymIndex = 4'h6,
    output logic [63:0]      laneTsGood = '0,
    output logic [15:0]      partnerAcceptRev = '0,
    output logic [15:0]      partnerCfgOk = '0
);
    timeunit 1ns;
    timeprecision 1ns;
    // Sweep symbols 6 to 15; only masked lanes arrive with swapped wires
    always @(posedge clk) begin
        rxSymIndex       <= (rxSymIndex == 4'hF) ? 4'h6 : rxSymIndex + 4'h1;
        rxSymValid       <= '1;
        rxSymInverted    <= invMask;
        laneTsGood       <= '1;
        partnerAcceptRev <= '1;
        partnerCfgOk     <= '1;
    end
endmodule
`default_nettype wire

/* dv/tb_port_merge_lane_width_control.sv */
// Self-checking bench for the port merge and width block
`include "port_merge_regs.svh"
`default_nettype none
module tb_port_merge_lane_width_control;
    timeunit 1ns;
    timeprecision 1ns;
    logic                      clk = 1'b0;
    logic                      reset = 1'b1;
    logic [7:0]                pair_merge_strap_n = 8'hFE;
    port_merge_pkg::port_in_t  hotplugIn [16] = '{default: '0};
    port_merge_pkg::port_out_t hotplugDrive [16] = '{default: '0};
    port_merge_pkg::port_out_t hotplugOut [16];
    port_merge_pkg::port_in_t  hotplugFiltered [16];
    logic [15:0]               portLinkUp = '0, portActivity = '0, partnerAutoChange = '0;
    logic [15:0]               portActive, portDownstream, txAutoChangeBit;
    logic [15:0]               partnerAcceptRev, partnerCfgOk;
    logic [63:0]               rxSymValid, rxSymInverted, laneTsGood, rxDataCorrected, txInvert;
    logic [63:0]               rxData = '0;
    logic [15:0]               partnerReqWidthVld = '0;
    logic [5:0]                partnerReqWidth = '0;
    logic [3:0]                rxExp;
    logic [3:0]                rxSymIndex;
    logic [7:0]                s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0]               s_axi_wdata = '0, s_axi_rdata;
    logic [1:0]                s_axi_bresp, s_axi_rresp;
    logic                      s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic                      s_axi_arvalid = 0, s_axi_rready = 0;
    logic                      s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic                      s_axi_rvalid;
    logic [33:0]               expQ [$];
    int                        error_cnt = 0, comparisons = 0;

    port_merge_lane_width_control i_port_merge_lane_width_control (
        .clk, .reset, .pair_merge_strap_n, .hotplugIn, .hotplugOut, .portLinkUp, .portActivity,
        .hotplugDrive, .portActive, .portDownstream, .hotplugFiltered, .rxSymValid,
        .rxSymInverted, .rxSymIndex, .rxData, .rxDataCorrected, .txInvert, .laneTsGood,
        .partnerAcceptRev, .partnerCfgOk, .partnerReqWidthVld, .partnerReqWidth,
        .partnerAutoChange, .laneReversed(), .txAutoChangeBit, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
    );
    link_partner_model i_link_partner_model (
        .clk, .invMask(64'h0000_0000_0000_0001), .rxSymValid, .rxSymInverted, .rxSymIndex,
        .laneTsGood, .partnerAcceptRev, .partnerCfgOk
    );

    initial forever #10 clk = ~clk;

    task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // A spent wait bound ends the run
    task automatic limit(input int n);
        if (n >= 50) begin
            error_cnt++;
            $display("ERROR %0t bus answer never came", $time);
            close_out();
        end
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        int n;
        @(posedge clk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        chk(34'(s_axi_bresp), 34'(r));
        s_axi_bready <= 1'b0;
        limit(n);
    endtask
    // Expected read word is queued here and judged by the watcher below
    task automatic axr(input logic [7:0] a, input logic [33:0] e);
        int n;
        @(posedge clk);
        expQ.push_back(e);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        s_axi_rready <= 1'b0;
        limit(n);
    endtask
    always @(posedge clk) begin
        if (s_axi_rvalid && s_axi_rready)
            chk({s_axi_rresp, s_axi_rdata}, expQ.pop_front());
    end
    // Pins and lane data wander; dead ports must ignore them
    always @(posedge clk) begin
        foreach (hotplugIn[i]) hotplugIn[i] <= 5'($urandom);
        rxData       <= {$urandom, $urandom};
        portLinkUp   <= 16'($urandom);
        portActivity <= 16'($urandom);
    end

    initial begin
        void'($urandom(57));
        @(posedge clk);
        foreach (hotplugDrive[i]) hotplugDrive[i] <= 7'($urandom);
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        repeat (4) @(posedge clk);
        pair_merge_strap_n <= 8'hFF; // board may move straps once reset is over
        repeat (200) @(posedge clk);
        chk(34'(portActive[2:0]), 34'h5);
        chk(34'(hotplugOut[1]), 34'h03);
        chk(34'(hotplugOut[2][6:2]), 34'(hotplugDrive[2][6:2]));
        chk(34'(hotplugFiltered[1]), 34'h1F);
        chk(34'(txInvert), 34'h0);
        chk(34'(txAutoChangeBit), 34'h0);
        axr(`OFF_SWITCH_CTL, 34'h0);
        axw(`OFF_PORT_SEL, 32'h0000_0000, `RESP_OKAY);
        axw(`OFF_LINK_CAP, 32'h0000_0010, `RESP_OKAY);
        axr(`OFF_LINK_CAP, 34'h80);
        axr(`OFF_LINK_STS, 34'h80);
        axw(`OFF_SWITCH_CTL, 32'h0000_0001, `RESP_OKAY);
        axw(`OFF_LINK_CAP, 32'h0000_0010, `RESP_OKAY);
        axr(`OFF_LINK_CAP, 34'h10);
        axw(`OFF_PHY_STATE, 32'h0000_0001, `RESP_OKAY);
        repeat (200) @(posedge clk);
        axr(`OFF_LINK_STS, 34'h10);
        axr(`OFF_POLARITY, 34'h1);
        @(posedge clk) rxExp = rxData[3:0] ^ 4'h1;
        @(posedge clk) chk(34'(rxDataCorrected[3:0]), 34'(rxExp));
        axw(`OFF_LINK_CTL, 32'h0000_0200, `RESP_OKAY);
        axr(`OFF_LINK_CTL, 34'h0);
        axw(`OFF_PORT_SEL, 32'h0000_0001, `RESP_OKAY);
        axw(`OFF_MODE_CTL, 32'h0000_0001, `RESP_OKAY);
        axr(`OFF_MODE_CTL, 34'h1);
        chk(34'(portDownstream[1]), 34'h0);
        axw(`OFF_PORT_SEL, 32'h0000_0002, `RESP_OKAY);
        axw(`OFF_MODE_CTL, 32'h0000_0001, `RESP_OKAY);
        chk(34'(portDownstream[2]), 34'h1);
        partnerAutoChange <= 16'h0004;
        partnerReqWidthVld <= 16'h0004;
        partnerReqWidth <= `W_X2;
        repeat (4) @(posedge clk);
        partnerAutoChange <= 16'h0000;
        axr(`OFF_LINK_STS, 34'h8020);
        axw(`OFF_LINK_STS, 32'h0000_8000, `RESP_OKAY);
        axr(`OFF_LINK_STS, 34'h20);
        axw(8'hFC, 32'h0000_0001, `RESP_SLVERR);
        axr(8'hFC, 34'h2_0000_0000);
        repeat (4) @(posedge clk);
        close_out();
    end
endmodule
`default_nettype wire
